// file: shared/tof_seq_regs.svh
// Timing constants for the time-of-flight drive sequencer
`ifndef TOF_SEQ_REGS_SVH
`define TOF_SEQ_REGS_SVH

// System clock period in ns (40 MHz)
`define CLK_PERIOD_NS        25
// Readout clock divider: 40 MHz / 8 = 5 MHz linear, / 4 = 10 MHz area
`define LIN_DIV              8
`define AREA_DIV             4
// Linear format: pixels per line
`define LIN_PIXELS           272
// Area format: per-row clocks split into charge transfer and pixels
`define ROW_XFER_CLKS        40
`define ROW_PIX_CLKS         168
`define ROW_TOTAL_CLKS       208
`define AREA_ROWS            128
// Gate and emission pulse widths in ns per range
`define PULSE_NS_4M5         30
`define PULSE_NS_6M          40
`define PULSE_NS_9M          60
// Width of counters
`define CNT_W                16

`endif

// file: shared/tof_seq_pkg.sv
// Types used by the controller end of the sequencer link and the testbench
`default_nettype none
package tof_seq_pkg;

  // Readout format of the sensor
  typedef enum logic [0:0] {
    FMT_LINEAR = 1'b0,
    FMT_AREA   = 1'b1
  } fmt_t;

  // Pulse width selection by maximum range
  typedef enum logic [1:0] {
    RANGE_4M5 = 2'h0,
    RANGE_6M  = 2'h1,
    RANGE_9M  = 2'h2
  } range_t;

  // Controller frame states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RSTRD = 6'h02,
    ST_EMIT  = 6'h04,
    ST_ECHO  = 6'h08,
    ST_AMB   = 6'h10,
    ST_READ  = 6'h20
  } ctl_state_t;

endpackage : tof_seq_pkg
`default_nettype wire

// file: shared/tof_link_if.sv
// Interface joining the timing controller and the sensor model
`timescale 1ns/100ps
`default_nettype none
interface tof_link_if;
  logic        first_transfer_gate;
  logic        second_transfer_gate;
  logic        charge_drain_gate;
  logic        pixel_reset;
  logic        read_clk_en;
  logic        row_start;
  logic        light_pulse;
  logic [11:0] first_phase_output;
  logic [11:0] second_phase_output;
  logic        pixel_valid;

  // Timing generator side
  modport ctl (
    output first_transfer_gate, second_transfer_gate, charge_drain_gate,
    output pixel_reset, read_clk_en, row_start, light_pulse,
    input  first_phase_output, second_phase_output, pixel_valid
  );
  // Sensor side
  modport dev (
    input  first_transfer_gate, second_transfer_gate, charge_drain_gate,
    input  pixel_reset, read_clk_en, row_start, light_pulse,
    output first_phase_output, second_phase_output, pixel_valid
  );
endinterface : tof_link_if
`default_nettype wire

// file: core/tof_clk_div.sv
// Divider producing a one-cycle readout clock enable
`timescale 1ns/100ps
`default_nettype none
module tof_clk_div #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  // Control
  input  wire logic         run_i,
  input  wire logic [W-1:0] div_i,
  // Enable pulse
  output logic              tick_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Count down to zero, restarting while stopped so phase is fixed
  always_comb begin
    if (!run_i || cnt_q == '0) begin
      cnt_d = div_i - W'(1);
    end else begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick_o = run_i && (cnt_q == '0);
endmodule : tof_clk_div
`default_nettype wire

// file: core/tof_sensor_dev.sv
// Sensor end: gate-driven charge accumulation and pixel-serial readout
`timescale 1ns/100ps
`default_nettype none
`include "tof_seq_regs.svh"
module tof_sensor_dev #(
  parameter int PIXW = 12
) (
  // Clock and reset
  input  wire logic      mclk_i,
  input  wire logic      rstn_i,
  // Stimulus standing in for the optical input
  input  wire logic      echo_i,
  input  wire logic      ambient_i,
  // Link
  tof_link_if.dev        link
);
  logic [PIXW-1:0] acc1_q, acc1_d;
  logic [PIXW-1:0] acc2_q, acc2_d;
  logic [PIXW-1:0] out1_q, out1_d;
  logic [PIXW-1:0] out2_q, out2_d;
  logic            vld_q, vld_d;
  logic            photo;

  // Photo charge present from echo or ambient light
  assign photo = echo_i || ambient_i;

  // Saturating add avoids wrap on bright scenes
  function automatic logic [PIXW-1:0] sat_inc(input logic [PIXW-1:0] v);
    sat_inc = (&v) ? v : v + PIXW'(1);
  endfunction : sat_inc

  // Accumulate into nodes; drain discards charge; reads are non-destructive
  always_comb begin
    acc1_d = acc1_q;
    acc2_d = acc2_q;
    out1_d = out1_q;
    out2_d = out2_q;
    vld_d  = 1'b0;
    if (link.pixel_reset) begin
      acc1_d = '0;
      acc2_d = '0;
    end else if (link.charge_drain_gate && !link.first_transfer_gate && !link.second_transfer_gate) begin
      acc1_d = acc1_q;
      acc2_d = acc2_q;
    end else if (photo) begin
      if (link.first_transfer_gate) acc1_d = sat_inc(acc1_q);
      if (link.second_transfer_gate) acc2_d = sat_inc(acc2_q);
    end
    if (link.read_clk_en) begin
      out1_d = acc1_q;
      out2_d = acc2_q;
      vld_d  = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc1_q <= '0;
      acc2_q <= '0;
      out1_q <= '0;
      out2_q <= '0;
      vld_q  <= 1'b0;
    end else begin
      acc1_q <= acc1_d;
      acc2_q <= acc2_d;
      out1_q <= out1_d;
      out2_q <= out2_d;
      vld_q  <= vld_d;
    end
  end

  assign link.first_phase_output  = out1_q;
  assign link.second_phase_output = out2_q;
  assign link.pixel_valid         = vld_q;
endmodule : tof_sensor_dev
`default_nettype wire

// file: core/tof_seq_ctl.sv
// Controller end: frame sequencing, gate drive, readout and distance math
`timescale 1ns/100ps
`default_nettype none
`include "tof_seq_regs.svh"
module tof_seq_ctl #(
  parameter int PIXW  = 12,
  parameter int CW    = `CNT_W,
  parameter int LINES = `AREA_ROWS
) (
  // Clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   rstn_i,
  // Frame control
  input  wire logic                   start_i,
  input  wire tof_seq_pkg::fmt_t      fmt_i,
  input  wire tof_seq_pkg::range_t    range_i,
  input  wire logic [CW-1:0]          reps_i,
  input  wire logic [3:0]             nd_reads_i,
  input  wire logic                   skip_reset_read_i,
  input  wire logic                   amb_sub_i,
  input  wire logic [PIXW-1:0]        saturation_threshold_i,
  // Light source
  output logic                        light_pulse_o,
  // Results
  output logic                        busy_o,
  output logic                        px_valid_o,
  output logic [PIXW-1:0]             px_delta_o,
  output logic [PIXW-1:0]             echo_delay_o,
  output logic                        px_sat_o,
  // Link
  tof_link_if.ctl                     link
);
  localparam int PW = 3;
  tof_seq_pkg::ctl_state_t st_q, st_d;
  logic [CW-1:0]   rep_q, rep_d;
  logic [PW-1:0]   ph_q, ph_d;
  logic [CW-1:0]   pix_q, pix_d;
  logic [CW-1:0]   row_q, row_d;
  logic [3:0]      nd_q, nd_d;
  logic            amb_q, amb_d;
  logic [PIXW-1:0] base1_q, base1_d, base2_q, base2_d;
  logic [PIXW-1:0] dly_q, dly_d, dlt_q, dlt_d;
  logic            pv_q, pv_d, sat_q, sat_d;
  logic [PW-1:0]   pw_cyc;
  logic            tick;
  logic [3:0]      div;
  logic [CW-1:0]   line_len, nrows;

  // Pulse width in clocks: ns rounded up to whole 25 ns cycles
  function automatic logic [PW-1:0] ns2cyc(input int ns);
    ns2cyc = PW'((ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  endfunction : ns2cyc

  // Width by range; coarse at 40 MHz, so 30 and 40 ns both give 2 cycles
  always_comb begin
    case (range_i)
      tof_seq_pkg::RANGE_6M: pw_cyc = ns2cyc(`PULSE_NS_6M);
      tof_seq_pkg::RANGE_9M: pw_cyc = ns2cyc(`PULSE_NS_9M);
      default:               pw_cyc = ns2cyc(`PULSE_NS_4M5);
    endcase
  end

  // Readout rate and geometry by format
  assign div      = (fmt_i == tof_seq_pkg::FMT_AREA) ? 4'(`AREA_DIV) : 4'(`LIN_DIV);
  assign line_len = (fmt_i == tof_seq_pkg::FMT_AREA) ? CW'(`ROW_TOTAL_CLKS) : CW'(`LIN_PIXELS);
  assign nrows    = (fmt_i == tof_seq_pkg::FMT_AREA) ? CW'(LINES) : CW'(1);

  tof_clk_div #(.W(4)) u_div (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .run_i  ((st_q == tof_seq_pkg::ST_READ) || (st_q == tof_seq_pkg::ST_RSTRD)),
    .div_i  (div),
    .tick_o (tick)
  );

  // Frame sequencer: reset read, emit/echo cycles, ambient pass, reads
  always_comb begin
    st_d  = st_q;
    rep_d = rep_q;
    ph_d  = ph_q;
    pix_d = pix_q;
    row_d = row_q;
    nd_d  = nd_q;
    amb_d = amb_q;
    case (st_q)
      tof_seq_pkg::ST_IDLE: begin
        if (start_i) begin
          rep_d = '0;
          ph_d  = '0;
          pix_d = '0;
          row_d = '0;
          nd_d  = '0;
          amb_d = 1'b0;
          st_d  = skip_reset_read_i ? tof_seq_pkg::ST_EMIT : tof_seq_pkg::ST_RSTRD;
        end
      end
      tof_seq_pkg::ST_EMIT: begin
        ph_d = ph_q + PW'(1);
        if (ph_q == pw_cyc - PW'(1)) begin
          ph_d = '0;
          st_d = tof_seq_pkg::ST_ECHO;
        end
      end
      tof_seq_pkg::ST_ECHO: begin
        ph_d = ph_q + PW'(1);
        if (ph_q == pw_cyc - PW'(1)) begin
          ph_d  = '0;
          rep_d = rep_q + CW'(1);
          st_d  = tof_seq_pkg::ST_AMB;
        end
      end
      tof_seq_pkg::ST_AMB: begin
        // One drain cycle between pulses discards ambient charge
        if (rep_q >= reps_i) begin
          rep_d = '0;
          st_d  = tof_seq_pkg::ST_READ;
        end else begin
          st_d  = tof_seq_pkg::ST_EMIT;
        end
      end
      tof_seq_pkg::ST_RSTRD, tof_seq_pkg::ST_READ: begin
        if (tick) begin
          pix_d = pix_q + CW'(1);
          if (pix_q == line_len - CW'(1)) begin
            pix_d = '0;
            row_d = row_q + CW'(1);
            if (row_q == nrows - CW'(1)) begin
              row_d = '0;
              if (st_q == tof_seq_pkg::ST_RSTRD) begin
                st_d = tof_seq_pkg::ST_EMIT;
              end else if (nd_q + 4'(1) < nd_reads_i) begin
                nd_d = nd_q + 4'(1);
                st_d = tof_seq_pkg::ST_EMIT;
              end else if (amb_sub_i && !amb_q) begin
                amb_d = 1'b1;
                nd_d  = '0;
                st_d  = tof_seq_pkg::ST_EMIT;
              end else begin
                st_d = tof_seq_pkg::ST_IDLE;
              end
            end
          end
        end
      end
      default: st_d = tof_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q  <= tof_seq_pkg::ST_IDLE;
      rep_q <= '0;
      ph_q  <= '0;
      pix_q <= '0;
      row_q <= '0;
      nd_q  <= '0;
      amb_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      rep_q <= rep_d;
      ph_q  <= ph_d;
      pix_q <= pix_d;
      row_q <= row_d;
      nd_q  <= nd_d;
      amb_q <= amb_d;
    end
  end

  // Gate drive; drain whenever neither transfer gate is on
  assign link.first_transfer_gate  = (st_q == tof_seq_pkg::ST_EMIT);
  assign link.second_transfer_gate = (st_q == tof_seq_pkg::ST_ECHO);
  assign link.charge_drain_gate    = !link.first_transfer_gate && !link.second_transfer_gate;
  assign link.pixel_reset          = (st_q == tof_seq_pkg::ST_IDLE);
  // Only pixel clocks sample; the 40 transfer clocks of an area row do not
  assign link.read_clk_en = tick && !(fmt_i == tof_seq_pkg::FMT_AREA && pix_q < CW'(`ROW_XFER_CLKS));
  assign link.row_start   = tick && (pix_q == '0);
  assign link.light_pulse = (st_q == tof_seq_pkg::ST_EMIT) && !amb_q;
  assign light_pulse_o    = link.light_pulse;

  // Arithmetic on returned samples: baseline subtraction and delay ratio
  always_comb begin
    base1_d = base1_q;
    base2_d = base2_q;
    dly_d   = dly_q;
    dlt_d   = dlt_q;
    sat_d   = sat_q;
    pv_d    = 1'b0;
    if (start_i && st_q == tof_seq_pkg::ST_IDLE) begin
      base1_d = '0;
      base2_d = '0;
    end else if (link.pixel_valid) begin
      // Later read minus earlier; ambient pass holds ambient baseline
      dlt_d = link.second_phase_output - base2_q;
      if (link.first_phase_output - base1_q + link.second_phase_output - base2_q != '0) begin
        dly_d = PIXW'((({{PIXW{1'b0}}, dlt_d}) << PIXW) /
                {{PIXW{1'b0}}, PIXW'(link.first_phase_output - base1_q + dlt_d)});
      end else begin
        dly_d = '0;
      end
      sat_d = (link.first_phase_output > saturation_threshold_i) ||
              (link.second_phase_output > saturation_threshold_i);
      pv_d  = 1'b1;
      base1_d = link.first_phase_output;
      base2_d = link.second_phase_output;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      base1_q <= '0;
      base2_q <= '0;
      dly_q   <= '0;
      dlt_q   <= '0;
      sat_q   <= 1'b0;
      pv_q    <= 1'b0;
    end else begin
      base1_q <= base1_d;
      base2_q <= base2_d;
      dly_q   <= dly_d;
      dlt_q   <= dlt_d;
      sat_q   <= sat_d;
      pv_q    <= pv_d;
    end
  end

  assign busy_o       = (st_q != tof_seq_pkg::ST_IDLE);
  assign px_valid_o   = pv_q;
  assign px_delta_o   = dlt_q;
  assign echo_delay_o = dly_q;
  assign px_sat_o     = sat_q;
endmodule : tof_seq_ctl
`default_nettype wire

// file: test/tof_link_sva.sv
// Link checker for the sequencer controller and sensor ends
`timescale 1ns/100ps
`default_nettype none
module tof_link_sva (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Link signals
  input wire logic first_transfer_gate,
  input wire logic second_transfer_gate,
  input wire logic charge_drain_gate,
  input wire logic pixel_reset,
  input wire logic read_clk_en,
  input wire logic row_start,
  input wire logic light_pulse,
  input wire logic pixel_valid
);
  // Everything runs on the one system clock
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  gate_overlap_a: assert property (!(first_transfer_gate && second_transfer_gate))
    else $error("transfer gates overlap");
  light_gate_a: assert property (light_pulse |-> first_transfer_gate && !charge_drain_gate)
    else $error("light outside first gate");
  drain_excl_a: assert property (charge_drain_gate |-> !first_transfer_gate && !second_transfer_gate)
    else $error("drain with a transfer gate on");
  second_follows_a: assert property ($fell(first_transfer_gate) |-> second_transfer_gate)
    else $error("second gate not right after first");
  gate_width_a: assert property ($rose(first_transfer_gate) |-> first_transfer_gate[*2] ##[1:2] !first_transfer_gate)
    else $error("first gate width out of range");
  drain_after_a: assert property ($fell(second_transfer_gate) |-> charge_drain_gate)
    else $error("no drain after second gate");
  sample_answer_a: assert property (pixel_valid |-> $past(read_clk_en))
    else $error("sample without enable");
  enable_gap_a: assert property (read_clk_en |=> !read_clk_en[*3])
    else $error("readout enables too close");
  reset_quiet_a: assert property (pixel_reset |-> !first_transfer_gate && !second_transfer_gate && !light_pulse)
    else $error("gates active during pixel reset");

  // Main scenarios reached
  cover property ($rose(light_pulse));
  cover property (pixel_valid);
  cover property (row_start);
endmodule : tof_link_sva
`default_nettype wire

// file: test/tof_sensor_drive_sequencer_tb.sv
// Testbench joining controller and sensor ends through the link
`timescale 1ns/100ps
`default_nettype none
module tof_sensor_drive_sequencer_tb;
  typedef struct packed {
    tof_seq_pkg::fmt_t   fmt;
    tof_seq_pkg::range_t rng;
    logic [15:0]         reps;
    logic [3:0]          nd;
    logic                skip;
    logic [31:0]         n_light;
    logic [31:0]         n_pix;
    logic [31:0]         width;
  } row_t;

  // Frame settings and expected counts; area runs with two rows
  row_t rows [5] = '{
    '{tof_seq_pkg::FMT_LINEAR, tof_seq_pkg::RANGE_4M5, 16'h0003, 4'h1, 1'b0, 32'h3, 32'h220, 32'h2},
    '{tof_seq_pkg::FMT_LINEAR, tof_seq_pkg::RANGE_6M, 16'h0001, 4'h2, 1'b1, 32'h2, 32'h220, 32'h2},
    '{tof_seq_pkg::FMT_LINEAR, tof_seq_pkg::RANGE_9M, 16'h0004, 4'h1, 1'b1, 32'h4, 32'h110, 32'h3},
    '{tof_seq_pkg::FMT_AREA, tof_seq_pkg::RANGE_4M5, 16'h0002, 4'h1, 1'b0, 32'h2, 32'h2A0, 32'h2},
    '{tof_seq_pkg::FMT_AREA, tof_seq_pkg::RANGE_9M, 16'h0000, 4'h1, 1'b1, 32'h1, 32'h150, 32'h3}
  };
  logic mclk_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0, skip_i = 1'b0, amb_i = 1'b0;
  logic echo_i = 1'b1, ambient_i = 1'b0, clr = 1'b0, lp_q = 1'b0, fg_q = 1'b0;
  tof_seq_pkg::fmt_t   fmt_i = tof_seq_pkg::FMT_LINEAR;
  tof_seq_pkg::range_t range_i = tof_seq_pkg::RANGE_4M5;
  logic [15:0] reps_i = 16'h0001;
  logic [3:0]  nd_i = 4'h1;
  logic [11:0] thr_i = 12'hFFF;
  logic        busy_o, px_valid_o, px_sat_o, light_o;
  logic [11:0] delta_o, delay_o;
  int error_cnt = 0, n_compared = 0, cyc = 0, rd_n = 272;
  int n_light, n_first, n_pv, n_px, n_sat, n_row, t0, t1, w;
  logic        got = 1'b0;
  logic [11:0] dq = 12'h000, yq = 12'h000;

  // 40 MHz system clock
  always #12.5 mclk_i = ~mclk_i;

  tof_link_if tof_link_if_inst ();
  tof_seq_ctl #(.LINES(2)) tof_seq_ctl_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .start_i(start_i), .fmt_i(fmt_i),
    .range_i(range_i), .reps_i(reps_i), .nd_reads_i(nd_i), .skip_reset_read_i(skip_i), .amb_sub_i(amb_i),
    .saturation_threshold_i(thr_i), .light_pulse_o(light_o), .busy_o(busy_o), .px_valid_o(px_valid_o),
    .px_delta_o(delta_o), .echo_delay_o(delay_o), .px_sat_o(px_sat_o), .link(tof_link_if_inst.ctl));
  tof_sensor_dev tof_sensor_dev_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .echo_i(echo_i), .ambient_i(ambient_i),
    .link(tof_link_if_inst.dev));
  tof_link_sva tof_link_sva_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .first_transfer_gate(tof_link_if_inst.first_transfer_gate),
    .second_transfer_gate(tof_link_if_inst.second_transfer_gate),
    .charge_drain_gate(tof_link_if_inst.charge_drain_gate), .pixel_reset(tof_link_if_inst.pixel_reset),
    .read_clk_en(tof_link_if_inst.read_clk_en), .row_start(tof_link_if_inst.row_start),
    .light_pulse(tof_link_if_inst.light_pulse), .pixel_valid(tof_link_if_inst.pixel_valid));

  // Counts pulses, samples and the span of the first read
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    lp_q <= light_o;
    fg_q <= tof_link_if_inst.first_transfer_gate;
    if (clr) begin
      {n_light, n_first, n_pv, n_px, n_sat, n_row, t0, t1, w} <= '0;
      {got, dq, yq} <= '0;
    end else begin
      if (light_o === 1'b1 && !lp_q) n_light <= n_light + 1;
      if (tof_link_if_inst.first_transfer_gate === 1'b1) w <= fg_q ? w + 1 : 1;
      if (tof_link_if_inst.first_transfer_gate === 1'b1 && !fg_q) n_first <= n_first + 1;
      if (tof_link_if_inst.pixel_valid === 1'b1) begin
        n_pv <= n_pv + 1;
        if (n_pv == 0) t0 <= cyc;
        if (n_pv == rd_n - 1) t1 <= cyc;
      end
      if (px_valid_o === 1'b1) n_px <= n_px + 1;
      if (px_valid_o === 1'b1 && px_sat_o === 1'b1) n_sat <= n_sat + 1;
      if (tof_link_if_inst.row_start === 1'b1) n_row <= n_row + 1;
      // First nonzero difference is the integrated charge over the previous read
      if (px_valid_o === 1'b1 && delta_o != 12'h000 && !got) begin
        got <= 1'b1;
        dq  <= delta_o;
        yq  <= delay_o;
      end
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %0d expected %0d", $time, what, seen, exp);
    end
  endtask : check

  // One frame; poke pulses start mid-frame, which must be ignored
  task automatic run_frame(input logic poke);
    int k;
    @(posedge mclk_i) #2 clr = 1'b1;
    @(posedge mclk_i) #2 clr = 1'b0;
    start_i = 1'b1;
    @(posedge mclk_i) #2 start_i = 1'b0;
    k = 0;
    while (busy_o !== 1'b0 && k < 20000) begin
      @(posedge mclk_i) #2 start_i = poke && (k == 100);
      k++;
    end
    // Last sample reaches the result outputs one cycle after idle
    repeat (3) @(posedge mclk_i);
    #2 check(k < 20000, 1, "frame end");
  endtask : run_frame

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // Ceiling well above the roughly 25k cycles the tests need
  always @(posedge mclk_i) begin
    if (cyc == 90000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge mclk_i);
    #2 rstn_i = 1'b1;
    foreach (rows[i]) begin
      fmt_i = rows[i].fmt;
      range_i = rows[i].rng;
      reps_i = rows[i].reps;
      nd_i = rows[i].nd;
      skip_i = rows[i].skip;
      rd_n = (rows[i].fmt == tof_seq_pkg::FMT_AREA) ? 336 : 272;
      run_frame(1'b0);
      check(n_light, rows[i].n_light, "light pulses");
      check(n_pv, rows[i].n_pix, "sensor samples");
      check(n_px, rows[i].n_pix, "result samples");
      check(w, rows[i].width, "gate width");
      check(t1 - t0, (rd_n == 336) ? 1500 : 2168, "read span");
      check(n_sat, 0, "saturation flags");
      check(n_row, rows[i].n_pix / ((rows[i].fmt == tof_seq_pkg::FMT_AREA) ? 168 : 272), "row starts");
      check(dq, rows[i].width * ((rows[i].reps == 16'h0000) ? 1 : rows[i].reps), "read difference");
      check(yq, 12'h800, "half pulse delay");
      $display("test row %0d done", i);
    end
    // Ambient pass plus a start pulse while busy
    {fmt_i, range_i, reps_i, nd_i, skip_i, amb_i, ambient_i, thr_i} = '0;
    reps_i = 16'h0002;
    nd_i = 4'h1;
    skip_i = 1'b1;
    amb_i = 1'b1;
    ambient_i = 1'b1;
    rd_n = 272;
    run_frame(1'b1);
    check(n_light, 2, "lit pulses");
    check(n_first, 4, "first gate pulses");
    check(n_sat > 0, 1, "saturation seen");
    check(dq, 4, "lit pass difference");
    repeat (4) @(posedge mclk_i);
    #2 check(busy_o, 1'b0, "start while busy");
    $display("test ambient done");
    // Reset in mid-frame returns both ends to idle
    start_i = 1'b1;
    repeat (60) @(posedge mclk_i);
    #2 rstn_i = 1'b0;
    start_i = 1'b0;
    #1 check(busy_o, 1'b0, "busy in reset");
    check(tof_link_if_inst.pixel_reset, 1'b1, "pixel reset level");
    check(tof_link_if_inst.charge_drain_gate, 1'b1, "drain in reset");
    check(tof_link_if_inst.first_transfer_gate, 1'b0, "gate in reset");
    repeat (8) @(posedge mclk_i);
    #2 rstn_i = 1'b1;
    // A full frame after release shows nothing stuck from the cut frame
    run_frame(1'b0);
    check(n_light, 2, "lit pulses after reset");
    check(n_first, 4, "gate pulses after reset");
    $display("test reset done");
    report_and_stop();
  end
endmodule : tof_sensor_drive_sequencer_tb
`default_nettype wire
